// *** design/stp_pkg.sv ***
package stp_pkg;
  // register map (byte addresses on apb)
  localparam logic [11:0] GTC_OFFSET     = 12'h023;  // register index; byte address is four times it
  localparam logic [11:0] CSEL_A_OFFSET  = 12'h100;
  localparam logic [11:0] CSEL_B_OFFSET  = 12'h104;
  localparam logic [11:0] STATUS_OFFSET  = 12'h108;
  localparam logic [11:0] GTC_ADDR       = {GTC_OFFSET[9:0], 2'h0};
  localparam logic [11:0] CSEL_A_ADDR    = CSEL_A_OFFSET;
  localparam logic [11:0] CSEL_B_ADDR    = CSEL_B_OFFSET;
  localparam logic [11:0] STATUS_ADDR    = STATUS_OFFSET;
  // general timer control fields
  localparam int          GTC_SYNC_BIT   = 7;
  localparam int          GTC_ASYNC_BIT  = 1;
  localparam int          GTC_SHARED_BIT = 0;
  localparam logic [7:0]  GTC_RESET      = 8'h00;
  localparam logic [2:0]  CSEL_RESET     = 3'h0;
  // prescaler
  localparam int          PRESC_W        = 10;
  localparam logic [9:0]  PRESC_RESET    = 10'h000;
  localparam logic [9:0]  PRESC_ONE      = 10'h001;
  localparam int          TAP_8_BIT      = 2;
  localparam int          TAP_64_BIT     = 5;
  localparam int          TAP_256_BIT    = 7;
  localparam int          TAP_1024_BIT   = 9;

  typedef enum logic [2:0] {
    CS_STOP     = 3'h0,
    CS_DIV1     = 3'h1,
    CS_DIV8     = 3'h2,
    CS_DIV64    = 3'h3,
    CS_DIV256   = 3'h4,
    CS_DIV1024  = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } stp_csel_t;

  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } stp_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } stp_apb_rsp_t;

  typedef struct packed {
    logic timer_a_count_clock;
    logic timer_b_count_clock;
  } stp_ticks_t;
endpackage

// *** design/stp_shared_timer_prescaler.sv ***
// Notes on behaviour
// RL1: one prescaler feeds both timers; each timer has its own clock select
// RL2: prescaler counter free-runs on clk whatever the clock selects say
// RL3: first prescaled count lands 1 to N+1 cycles after enabling
// RL4: prescaler reset restarts the period for both timers
// RL5: clock select 1 ticks every system clock, no prescaling
// RL6: taps give divide by 8, 64, 256 and 1024
// RL7: each count pin passes a synchroniser then an edge detector
// RL8: rising-edge flops capture the pin; latch stage modelled as first flop
// RL9: one tick per rising edge at select 7, falling edge at select 6
// RL10: pin edge reaches a tick 2.5 to 3.5 cycles later; the flop model here gives 2 to 3
// RL11: software switches external mode only while the pin is steady
// RL12: external clock half period must exceed one system clock
// RL13: pin edge ticks bypass the prescaler entirely
// RL14: in sync hold mode both prescaler-reset bits keep the written value
// RL15: writing sync hold mode to zero clears both prescaler-reset bits
// RL16: shared prescaler reset clears itself next cycle unless sync hold
// RL17: select 0 stops the timer; 1..5 select div1, 8, 64, 256, 1024
// RL18: pin edges count even when the pin is driven as an output
// RL19: control bits 6..2 read zero, ignore writes; reset value zero
//
// Implementation choice: register access over APB.
module stp_shared_timer_prescaler (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire stp_pkg::stp_apb_req_t apb_req,
  output stp_pkg::stp_apb_rsp_t      apb_rsp,
  input  wire logic                  count_pin_a,
  input  wire logic                  count_pin_b,
  output stp_pkg::stp_ticks_t        ticks,
  output logic                       async_prescaler_reset
);
  import stp_pkg::*;

  // control register state
  logic               sync_hold_mode;
  logic               shared_prescaler_reset;
  logic [2:0]         clock_select_a;
  logic [2:0]         clock_select_b;
  logic               next_shared_rst;
  logic               next_async_rst;

  // prescaler counter and its tap strobes
  logic [PRESC_W-1:0] presc;
  logic [PRESC_W-1:0] next_presc;
  logic               tap_8;
  logic               tap_64;
  logic               tap_256;
  logic               tap_1024;

  // pin path: two synchroniser stages, then edge history
  logic [1:0]         pin_meta;
  logic [1:0]         pin_sync;
  logic [1:0]         pin_prev;
  logic               rise_a;
  logic               fall_a;
  logic               rise_b;
  logic               fall_b;

  // bus decode and registered answer
  logic               wr_en;
  logic               rd_en;
  logic               setup_phase;
  logic               gtc_wr;
  logic               csel_a_wr;
  logic               csel_b_wr;
  logic [31:0]        next_rdata;
  logic               next_err;
  logic [31:0]        rdata_q;
  logic               err_q;

  // next tick of each timer, registered below
  logic               next_tick_a;
  logic               next_tick_b;

  // tap strobe: high for one cycle when the low bits of the counter wrap
  // all-ones test, so each tap fires once per period of its own width
  function automatic logic tap_hit(input logic [PRESC_W-1:0] cnt, input int msb);
    logic hit;
    hit = 1'b1;
    for (int i = 0; i < PRESC_W; i++) begin
      if (i <= msb && !cnt[i]) begin
        hit = 1'b0;
      end
    end
    return hit;
  endfunction

  // address match for one register
  // full compare, so aliases of a register never decode
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] target);
    return addr == target;
  endfunction

  // clock select field of a write word, same place for both timers
  function automatic logic [2:0] csel_field(input logic [31:0] word);
    return word[2:0];
  endfunction

  // one-cycle edge strobe from synchronised level and its history
  // only synchronised levels come in, never the raw pin
  function automatic logic edge_of(input logic cur, input logic prev, input logic rising);
    logic e;
    if (rising) begin
      e = cur && !prev;
    end else begin
      e = !cur && prev;
    end
    return e;
  endfunction

  // control register image
  // bits 6..2 are not stored, so they read zero and ignore writes
  function automatic logic [7:0] gtc_image(input logic sync, input logic async_rst, input logic shared_rst);
    logic [7:0] img;
    img = GTC_RESET;
    img[GTC_SYNC_BIT]   = sync;
    img[GTC_ASYNC_BIT]  = async_rst;
    img[GTC_SHARED_BIT] = shared_rst;
    return img;
  endfunction

  // pick a tick source for one timer from its select field
  // every code is legal, so no default is needed
  function automatic logic pick_tick(input logic [2:0] csel, input logic rise, input logic fall,
                                     input logic t8, input logic t64, input logic t256,
                                     input logic t1024);
    logic t;
    t = 1'b0;
    unique case (stp_csel_t'(csel))
      CS_STOP: begin
        t = 1'b0;  // [RL17]
      end
      CS_DIV1: begin
        t = 1'b1;  // [RL5]
      end
      CS_DIV8: begin
        t = t8;  // [RL6]
      end
      CS_DIV64: begin
        t = t64;
      end
      CS_DIV256: begin
        t = t256;
      end
      CS_DIV1024: begin
        t = t1024;
      end
      CS_EXT_FALL: begin
        t = fall;  // [RL9] [RL13]
      end
      CS_EXT_RISE: begin
        t = rise;  // [RL9] [RL13]
      end
    endcase
    return t;
  endfunction

  // bus decode: writes land at the end of the access phase; reads are
  // taken in the setup phase so the data stands through the access
  assign wr_en       = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en       = apb_req.psel && !apb_req.pwrite;
  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign gtc_wr      = wr_en && reg_hit(apb_req.paddr, GTC_ADDR);
  assign csel_a_wr   = wr_en && reg_hit(apb_req.paddr, CSEL_A_ADDR);
  assign csel_b_wr   = wr_en && reg_hit(apb_req.paddr, CSEL_B_ADDR);

  // free-running prescaler; only the reset bit restarts it, never the selects
  always_comb begin
    if (shared_prescaler_reset) begin
      next_presc = PRESC_RESET;  // [RL4]
    end else begin
      next_presc = presc + PRESC_ONE;  // [RL2]
    end
  end

  // one counter for both timers, so a restart moves both phases at once
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc <= PRESC_RESET;
    end else begin
      presc <= next_presc;  // [RL1] [RL2]
    end
  end

  // tap strobes; phase is free w.r.t. enable, hence 1..N+1 to first count
  // taps stay low while the reset bit holds, so held timers cannot creep
  always_comb begin
    tap_8    = tap_hit(presc, TAP_8_BIT) && !shared_prescaler_reset;  // [RL3] [RL6]
    tap_64   = tap_hit(presc, TAP_64_BIT) && !shared_prescaler_reset;
    tap_256  = tap_hit(presc, TAP_256_BIT) && !shared_prescaler_reset;
    tap_1024 = tap_hit(presc, TAP_1024_BIT) && !shared_prescaler_reset;
  end

  // pin synchroniser; first stage stands in for the transparent-high latch
  // nothing but the second stage may read the first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end else begin
      pin_meta <= {count_pin_b, count_pin_a};  // [RL7] [RL8] [RL18]
      pin_sync <= pin_meta;
    end
  end

  // edge history reads only the second stage
  // resets low like an idle pin, so no false edge follows reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_prev <= 2'h0;
    end else begin
      pin_prev <= pin_sync;  // [RL7]
    end
  end

  // edge strobes per pin, one cycle each
  assign rise_a = edge_of(pin_sync[0], pin_prev[0], 1'b1);
  assign fall_a = edge_of(pin_sync[0], pin_prev[0], 1'b0);
  assign rise_b = edge_of(pin_sync[1], pin_prev[1], 1'b1);
  assign fall_b = edge_of(pin_sync[1], pin_prev[1], 1'b0);

  // tick source per timer
  // pin strobes go straight to the timer, never through the divider chain
  always_comb begin
    next_tick_a = pick_tick(clock_select_a, rise_a, fall_a, tap_8, tap_64, tap_256, tap_1024);  // [RL13]
    next_tick_b = pick_tick(clock_select_b, rise_b, fall_b, tap_8, tap_64, tap_256, tap_1024);  // [RL13]
  end

  // registered ticks; pin edge to tick is three edges
  // that puts the count 2 to 3 cycles after the pin moves
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ticks <= '0;
    end else begin
      ticks.timer_a_count_clock <= next_tick_a;  // [RL10] [RL1]
      ticks.timer_b_count_clock <= next_tick_b;  // [RL10] [RL1]
    end
  end

  // sync hold mode bit
  // plain read-write bit, cleared only by software or reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_hold_mode <= 1'b0;
    end else if (gtc_wr) begin
      sync_hold_mode <= apb_req.pwdata[GTC_SYNC_BIT];
    end
  end

  // next value of both prescaler-reset bits; a write wins over the self-clear
  // with sync hold clear a written one lives exactly one cycle
  always_comb begin
    next_shared_rst = shared_prescaler_reset;
    next_async_rst  = async_prescaler_reset;
    if (gtc_wr) begin
      next_shared_rst = apb_req.pwdata[GTC_SHARED_BIT];  // held under sync hold [RL14] [RL16]
      next_async_rst  = apb_req.pwdata[GTC_ASYNC_BIT];  // [RL14]
    end else if (!sync_hold_mode) begin
      next_shared_rst = 1'b0;  // clears once sync hold is off [RL15] [RL16]
      next_async_rst  = 1'b0;  // [RL15]
    end
  end

  // shared prescaler reset bit
  // restarts both timers' prescaled period, not only the writer's
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shared_prescaler_reset <= 1'b0;
    end else begin
      shared_prescaler_reset <= next_shared_rst;  // [RL4] [RL16]
    end
  end

  // async prescaler reset bit, same holding scheme
  // only passed out; the other timer's prescaler lives elsewhere
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      async_prescaler_reset <= 1'b0;
    end else begin
      async_prescaler_reset <= next_async_rst;  // [RL14] [RL15]
    end
  end

  // timer a clock select
  // own field, so each timer picks its tap independently
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_select_a <= CSEL_RESET;
    end else if (csel_a_wr) begin
      clock_select_a <= csel_field(apb_req.pwdata);  // [RL1]
    end
  end

  // timer b clock select
  // same shared taps as timer a, different choice allowed
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_select_b <= CSEL_RESET;
    end else if (csel_b_wr) begin
      clock_select_b <= csel_field(apb_req.pwdata);  // [RL1]
    end
  end

  // read mux; unmapped address answers slverr with zero data
  // writes to an unmapped address change nothing
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    unique case (apb_req.paddr)
      GTC_ADDR: begin
        next_rdata[7:0] = gtc_image(sync_hold_mode, async_prescaler_reset, shared_prescaler_reset);  // [RL19]
      end
      CSEL_A_ADDR: begin
        next_rdata[2:0] = clock_select_a;
      end
      CSEL_B_ADDR: begin
        next_rdata[2:0] = clock_select_b;
      end
      STATUS_ADDR: begin
        next_rdata[PRESC_W-1:0] = presc;
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  // read data taken in the setup cycle, so the access phase needs one edge
  // it stands until the next setup cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else if (setup_phase) begin
      if (rd_en) begin
        rdata_q <= next_rdata;
      end else begin
        rdata_q <= 32'h0000_0000;  // writes read back nothing
      end
      err_q <= next_err;
    end
  end

  // zero wait states
  // the answer struct has one driver, a single continuous assignment
  assign apb_rsp = '{pready: 1'b1, pslverr: err_q, prdata: rdata_q};
endmodule

// *** bench/stp_shared_timer_prescaler_props.sv ***
module stp_props (
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire stp_pkg::stp_apb_req_t apb_req,
  input wire stp_pkg::stp_apb_rsp_t apb_rsp,
  input wire logic                  count_pin_a,
  input wire logic                  count_pin_b,
  input wire stp_pkg::stp_ticks_t   ticks,
  input wire logic                  async_prescaler_reset
);
  import stp_pkg::*;
  logic [2:0] csel;
  logic [3:0] age;
  logic       acc;
  logic       wgt;
  logic       tk;
  // access phase and control-register write decode
  assign acc = apb_req.psel && apb_req.penable;
  assign wgt = acc && apb_req.pwrite && apb_req.paddr == GTC_ADDR;
  assign tk = ticks.timer_a_count_clock;
  // mirror timer a select; age keeps judging off until a switch settles
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      csel <= CSEL_RESET;
      age <= 4'h0;
    end else if (acc && apb_req.pwrite && apb_req.paddr == CSEL_A_ADDR) begin
      csel <= apb_req.pwdata[2:0];
      age <= 4'h0;
    end else if (age != 4'hf) begin
      age <= age + 4'h1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_pulse;
    async_prescaler_reset ##1 !async_prescaler_reset;
  endsequence
  property p_div1;
    csel == CS_DIV1 && age == 4'hf |-> tk;
  endproperty
  a_div1: assert property (p_div1) else $error("tick missing at select 1");
  property p_div8;
    csel == CS_DIV8 && age == 4'hf && tk |=> !tk [*7];
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 tick too early");
  property p_stop;
    csel == CS_STOP && age == 4'hf |-> !tk;
  endproperty
  a_stop: assert property (p_stop) else $error("tick while stopped");
  property p_rise;
    csel == CS_EXT_RISE && age == 4'hf && $rose(count_pin_a) |-> ##[2:4] tk;
  endproperty
  a_rise: assert property (p_rise) else $error("pin edge gave no tick");
  property p_hold;
    wgt && apb_req.pwdata[7] && apb_req.pwdata[1] |=> async_prescaler_reset [*4];
  endproperty
  a_hold: assert property (p_hold) else $error("held reset dropped");
  property p_pulse;
    wgt && !apb_req.pwdata[7] && apb_req.pwdata[1] && !async_prescaler_reset |=> s_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset not one cycle");
  property p_clear;
    wgt && apb_req.pwdata[7:0] == 8'h00 && async_prescaler_reset |-> ##[1:2] !async_prescaler_reset;
  endproperty
  a_clear: assert property (p_clear) else $error("held reset not cleared");
  property p_rd0;
    acc && !apb_req.pwrite && apb_req.paddr == GTC_ADDR |-> apb_rsp.prdata[6:2] == 5'h0;
  endproperty
  a_rd0: assert property (p_rd0) else $error("unused control bits not zero");
endmodule

bind stp_shared_timer_prescaler stp_props props_u (.clk(clk), .sys_rst(sys_rst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .count_pin_a(count_pin_a), .count_pin_b(count_pin_b), .ticks(ticks),
  .async_prescaler_reset(async_prescaler_reset));

// *** bench/stp_pin_src.sv ***
module stp_pin_src #(
  parameter int HALF = 4
) (
  input  wire logic clk,
  input  wire logic run,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial pin = 1'b0;
  // stands still unless run, so selects switch on a steady pin
  always @(posedge clk) begin
    if (run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) pin <= ~pin;
    end
  end
endmodule

// *** bench/stp_shared_timer_prescaler_bench.sv ***
module stp_shared_timer_prescaler_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import stp_pkg::*;
  logic         clk = 0;
  logic         sys_rst = 1;
  logic         run = 0;
  stp_apb_req_t req = '0;
  stp_apb_rsp_t rsp;
  stp_ticks_t   tk;
  logic         pa, pb, apr, e;
  logic [31:0]  q;
  int           mismatches = 0, compares = 0, na = 0, nb = 0, a0, b0, ta, tb;
  always #2.5 clk = ~clk;
  stp_shared_timer_prescaler dut_u (.clk(clk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
    .count_pin_a(pa), .count_pin_b(pb), .ticks(tk), .async_prescaler_reset(apr));
  stp_pin_src #(.HALF(4)) src_a (.clk(clk), .run(run), .pin(pa));
  stp_pin_src #(.HALF(8)) src_b (.clk(clk), .run(run), .pin(pb));
  // tick tallies of both timers
  always @(posedge clk) begin
    na <= na + int'(tk.timer_a_count_clock === 1'b1);
    nb <= nb + int'(tk.timer_b_count_clock === 1'b1);
  end
  task chk(string nm, logic [31:0] x, logic [31:0] got);
    compares++;
    if (got !== x) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, x, got);
    end
  endtask
  task test_done;
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one apb transfer; held until pready is seen at an edge
  task xfer(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1) @(posedge clk);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask
  task rd(logic [11:0] a, logic [31:0] x, logic xe = 1'b0);
    xfer(1'b0, a, 32'h0);
    chk("prdata", x, q);
    chk("pslverr", xe, e);
  endtask
  // ticks expected in 2048 cycles; per is the pin period
  function int want(int s, int per);
    int dv[8];
    dv = '{0, 1, 8, 64, 256, 1024, per, per};
    return dv[s] == 0 ? 0 : 2048 / dv[s];
  endfunction
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(GTC_ADDR, 32'h0);
    rd(CSEL_A_ADDR, 32'h0);
    rd(12'h200, 32'h0, 1'b1);
    xfer(1'b1, GTC_ADDR, 32'hff);
    rd(GTC_ADDR, 32'h83);
    chk("async_reset", 32'h1, apr);
    xfer(1'b1, GTC_ADDR, 32'h0);
    rd(GTC_ADDR, 32'h0);
    xfer(1'b1, GTC_ADDR, 32'h03);
    rd(GTC_ADDR, 32'h0);
    // every select on a, mirrored select on b
    for (int s = 0; s < 8; s++) begin
      run <= 1'b0;
      xfer(1'b1, CSEL_A_ADDR, s);
      xfer(1'b1, CSEL_B_ADDR, 7 - s);
      run <= 1'b1;
      repeat (16) @(posedge clk);
      a0 = na;
      b0 = nb;
      repeat (2048) @(posedge clk);
      chk("ticks_a", want(s, 8), na - a0);
      chk("ticks_b", want(7 - s, 16), nb - b0);
    end
    // hold both timers, then release them together
    xfer(1'b1, CSEL_A_ADDR, CS_DIV8);
    xfer(1'b1, CSEL_B_ADDR, CS_DIV64);
    xfer(1'b1, GTC_ADDR, 32'h81);
    repeat (4) @(posedge clk);
    a0 = na;
    b0 = nb;
    repeat (200) @(posedge clk);
    chk("held_ticks", 32'h0, na - a0 + nb - b0);
    rd(STATUS_ADDR, 32'h0);
    xfer(1'b1, GTC_ADDR, 32'h0);
    ta = 0;
    tb = 0;
    for (int i = 1; i < 100; i++) begin
      @(negedge clk);
      if (ta == 0 && tk.timer_a_count_clock === 1'b1) ta = i;
      if (tb == 0 && tk.timer_b_count_clock === 1'b1) tb = i;
    end
    chk("first_a", 32'h1, ta inside {[1:10]});
    chk("b_after_a", 56, tb - ta);
    test_done();
  end
  // hang guard
  initial begin
    #150us;
    mismatches++;
    test_done();
  end
endmodule
